// >>> inc/dfris_pkg.sv
/*
  package for the frequency reference input selector: register map, field
  layouts, function codes, timing constants and carrier structs.
  assumes a single 200 MHz clock domain and AHB-Lite register access.
*/
package dfris_pkg;

  localparam int unsigned CLK_MHZ       = 200;
  localparam int unsigned JOG_LIMIT_MS  = 500;
  localparam int unsigned JOG_LIMIT_CYC = JOG_LIMIT_MS * 1000 * CLK_MHZ;
  localparam int unsigned FREQ_W        = 16;
  localparam int unsigned NUM_DI        = 6;
  localparam int unsigned NUM_PRESET    = 16;

  // input function codes
  localparam logic [6:0] FN_FWD    = 7'h00;
  localparam logic [6:0] FN_REV    = 7'h01;
  localparam logic [6:0] FN_MS1    = 7'h02;
  localparam logic [6:0] FN_MS2    = 7'h03;
  localparam logic [6:0] FN_MS3    = 7'h04;
  localparam logic [6:0] FN_MS4    = 7'h05;
  localparam logic [6:0] FN_JOGF   = 7'h06;
  localparam logic [6:0] FN_JOGR   = 7'h07;
  localparam logic [6:0] FN_UP     = 7'h08;
  localparam logic [6:0] FN_DOWN   = 7'h09;
  localparam logic [6:0] FN_HOLD   = 7'h0b;
  localparam logic [6:0] FN_ALTRUN = 7'h0c;
  localparam logic [6:0] FN_ALTFRQ = 7'h0d;
  localparam logic [6:0] FN_ESTOP  = 7'h0e;
  localparam logic [6:0] FN_PIDOFF = 7'h10;
  localparam logic [6:0] FN_LOCREM = 7'h1b;
  localparam logic [6:0] FN_JOGSEL = 7'h1d;
  localparam logic [6:0] FN_ACC2   = 7'h1e;

  // frequency source and direction lock settings
  localparam logic [1:0] SRC_KEYPAD = 2'h0;
  localparam logic [1:0] SRC_TERM   = 2'h1;
  localparam logic [1:0] SRC_UPDN   = 2'h2;
  localparam logic [1:0] LOCK_FWD   = 2'h1;
  localparam logic [1:0] LOCK_REV   = 2'h2;

  // register byte offsets
  localparam logic [7:0] A_CTRL    = 8'h00;
  localparam logic [7:0] A_FUNC    = 8'h04;
  localparam logic [7:0] A_JOGF    = 8'h08;
  localparam logic [7:0] A_LIMITS  = 8'h0c;
  localparam logic [7:0] A_TIMES1  = 8'h10;
  localparam logic [7:0] A_TIMES2  = 8'h14;
  localparam logic [7:0] A_ESTOP   = 8'h18;
  localparam logic [7:0] A_STATUS  = 8'h1c;
  localparam logic [7:0] A_FREQOUT = 8'h20;
  localparam logic [7:0] A_PRESET  = 8'h40;

  // control register fields
  localparam int unsigned C_FSRC   = 0;
  localparam int unsigned C_AFSRC  = 2;
  localparam int unsigned C_RSRC   = 4;
  localparam int unsigned C_ARSRC  = 6;
  localparam int unsigned C_LOCK   = 8;
  localparam int unsigned C_RETAIN = 10;
  localparam int unsigned C_AUXM   = 11;
  localparam int unsigned C_PIDEN  = 12;
  localparam int unsigned C_STOPM  = 13;
  localparam int unsigned C_PWRDN  = 14;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [FREQ_W-1:0] UPPER_RST = 16'h1770;
  localparam logic [FREQ_W-1:0] TIME_RST  = 16'h0064;

  typedef enum logic [1:0] {
    DFRIS_IDLE = 2'b00,
    DFRIS_RAMP = 2'b01,
    DFRIS_ESTP = 2'b11,
    DFRIS_HALT = 2'b10
  } dfris_mode_e;

  typedef struct packed {
    logic [FREQ_W-1:0] target;
    logic [FREQ_W-1:0] acc_time;
    logic [FREQ_W-1:0] dec_time;
    logic              hold;
    logic              run;
  } dfris_ramp_s;

  typedef struct packed {
    logic        sel;
    logic [31:0] addr;
    logic        write;
  } dfris_addr_s;

endpackage

// >>> core/dfris_ramp.sv
/*
  ramp generator: moves the output frequency toward a target, one step each
  time a rate counter expires; hold freezes it.
  assumes times in ticks per unit of frequency less one, clock enable from the top.
*/
`timescale 1ns/100ps
module dfris_ramp
  import dfris_pkg::*;
#(
  parameter int unsigned W = FREQ_W
) (
  input  wire logic          hclk,
  input  wire logic          hresetn,
  input  wire logic          clk_en,
  input  dfris_pkg::dfris_ramp_s cmd,
  output logic [W-1:0]       freq_out,
  output logic               at_target
);

  logic [W-1:0] freq_q;
  logic [W-1:0] freq_d;
  logic [W-1:0] tick_q;
  logic [W-1:0] tick_d;
  logic [W-1:0] goal;

  assign goal      = cmd.run ? cmd.target : '0;
  assign at_target = (freq_q == goal);
  assign freq_out  = freq_q;

  wire going_up = goal > freq_q;
  wire [W-1:0] period = going_up ? cmd.acc_time : cmd.dec_time;
  wire step = (tick_q >= period) && !at_target && !cmd.hold;

  assign tick_d = (cmd.hold || at_target || step) ? '0 : tick_q + W'(1);
  assign freq_d = !step ? freq_q : (going_up ? freq_q + W'(1) : freq_q - W'(1));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      freq_q <= '0;
      tick_q <= '0;
    end else if (clk_en) begin
      freq_q <= freq_d;
      tick_q <= tick_d;
    end
  end

endmodule // dfris_ramp

// >>> core/dfris_top.sv
/*
  frequency reference input selector: decodes the multi-function inputs,
  picks the frequency reference, drives the ramp and flags warnings.
  assumes inputs synchronous to hclk, AHB-Lite with one slave, zero waits.
*/
`timescale 1ns/100ps
module dfris_top
  import dfris_pkg::*;
#(
  parameter int unsigned W        = FREQ_W,
  parameter int unsigned JOG_CYC  = JOG_LIMIT_CYC
) (
  input  wire logic                   hclk,
  input  wire logic                   hresetn,
  input  wire logic                   clk_en,
  input  wire logic                   hsel,
  input  wire logic [31:0]            haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic                   hready,
  input  wire logic [31:0]            hwdata,
  output logic [31:0]                 hrdata,
  output logic                        hreadyout,
  output logic                        hresp,
  input  wire logic [NUM_DI-1:0]      di_in,
  input  wire logic [W-1:0]           analog_input_one,
  input  wire logic [W-1:0]           analog_input_two,
  input  wire logic [W-1:0]           alt_freq_ref,
  input  wire logic                   alt_run_fwd,
  input  wire logic                   alt_run_rev,
  input  wire logic                   local_run_fwd,
  input  wire logic                   local_run_rev,
  input  wire logic                   power_loss,
  output logic [W-1:0]                freq_target,
  output logic [W-1:0]                freq_output,
  output logic                        run_active,
  output logic                        run_reverse,
  output logic                        jog_timeout_stop,
  output logic                        stop_coast,
  output logic                        run_direction_warning,
  output logic                        input_config_error
);

  dfris_mode_e mode_q, mode_d;
  logic [31:0]  ctrl_q;
  logic [41:0]  func_q;
  logic [W-1:0] jog_q, upper_q, lower_q, acc1_q, dec1_q, acc2_q, dec2_q, edec_q;
  logic [W-1:0] preset_q [NUM_PRESET];
  logic [W-1:0] updn_q, updn_d, saved_q, tgt_q, tgt_d;
  logic [31:0]  jog_cnt_q;
  logic         jog_stop_q;
  dfris_addr_s  ap_q;
  logic [31:0]  rdata_q;

  function automatic logic fn_active(input logic [41:0] fsel, input logic [NUM_DI-1:0] di,
                                     input logic [6:0] code);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < NUM_DI; i++)
      if (fsel[i*7 +: 7] == code && di[i]) hit = 1'b1;
    return hit;
  endfunction

  function automatic logic fn_assigned(input logic [41:0] fsel, input logic [6:0] code);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < NUM_DI; i++)
      if (fsel[i*7 +: 7] == code) hit = 1'b1;
    return hit;
  endfunction

  function automatic logic [W-1:0] clamp(input logic [W-1:0] v, input logic [W-1:0] lo,
                                         input logic [W-1:0] hi);
    return (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  // preset window decode, shared by the read mux and the write path
  function automatic logic pre_hit(input logic [7:0] off);
    return (off >= A_PRESET) && (off < A_PRESET + 8'(4 * NUM_PRESET));
  endfunction

  function automatic logic [3:0] pre_slot(input logic [7:0] off);
    return 4'((off - A_PRESET) >> 2);
  endfunction

  // decoded inputs
  wire fsel_ms1  = fn_active(func_q, di_in, FN_MS1);
  wire fsel_ms2  = fn_active(func_q, di_in, FN_MS2);
  wire fsel_ms3  = fn_active(func_q, di_in, FN_MS3);
  wire fsel_ms4  = fn_active(func_q, di_in, FN_MS4);
  wire jog_sel   = fn_active(func_q, di_in, FN_JOGSEL);
  wire jog_fwd   = fn_active(func_q, di_in, FN_JOGF);
  wire jog_rev   = fn_active(func_q, di_in, FN_JOGR);
  wire up_in     = fn_active(func_q, di_in, FN_UP);
  wire dn_in     = fn_active(func_q, di_in, FN_DOWN);
  wire hold_in   = fn_active(func_q, di_in, FN_HOLD);
  wire alt_run   = fn_active(func_q, di_in, FN_ALTRUN);
  wire alt_frq   = fn_active(func_q, di_in, FN_ALTFRQ);
  wire estop_in  = fn_active(func_q, di_in, FN_ESTOP);
  wire pid_off   = fn_active(func_q, di_in, FN_PIDOFF);
  wire local_in  = fn_active(func_q, di_in, FN_LOCREM);
  wire acc2_in   = fn_active(func_q, di_in, FN_ACC2);
  wire term_fwd  = fn_active(func_q, di_in, FN_FWD);
  wire term_rev  = fn_active(func_q, di_in, FN_REV);
  wire locrem_on = fn_assigned(func_q, FN_LOCREM);
  wire up_asg    = fn_assigned(func_q, FN_UP);
  wire dn_asg    = fn_assigned(func_q, FN_DOWN);

  wire [1:0] fsrc_main = ctrl_q[C_FSRC +: 2];
  wire [1:0] fsrc_alt  = ctrl_q[C_AFSRC +: 2];
  wire [1:0] rsrc_main = ctrl_q[C_RSRC +: 2];
  wire [1:0] rsrc_alt  = ctrl_q[C_ARSRC +: 2];
  wire [1:0] dir_lock  = ctrl_q[C_LOCK +: 2];
  wire       retain    = ctrl_q[C_RETAIN];
  wire       aux_mode  = ctrl_q[C_AUXM];
  wire       pid_en    = ctrl_q[C_PIDEN];
  wire       stop_mode = ctrl_q[C_STOPM];

  // local/remote overrides the main/alternative switches
  wire       loc_mode  = locrem_on && local_in;
  wire [1:0] fsrc      = loc_mode ? SRC_KEYPAD : (alt_frq ? fsrc_alt : fsrc_main);
  wire [1:0] rsrc      = loc_mode ? SRC_KEYPAD : (alt_run ? rsrc_alt : rsrc_main);
  wire       term_runs = (rsrc == SRC_TERM);

  wire run_fwd_in = term_runs ? term_fwd : (rsrc == SRC_KEYPAD ? local_run_fwd : alt_run_fwd);
  wire run_rev_in = term_runs ? term_rev : (rsrc == SRC_KEYPAD ? local_run_rev : alt_run_rev);
  // jog contacts are honoured only from terminals
  wire jog_run    = term_runs && (jog_fwd || jog_rev);
  wire want_fwd   = jog_run ? jog_fwd : run_fwd_in;
  wire want_rev   = jog_run ? (jog_rev && !jog_fwd) : (run_rev_in && !run_fwd_in);

  // direction lock vetoes the run and raises the warning
  wire dir_bad = (dir_lock == LOCK_FWD && want_rev) || (dir_lock == LOCK_REV && want_fwd);
  wire run_req = (want_fwd || want_rev) && !dir_bad && !jog_stop_q;

  // multi-speed selection
  wire [3:0] ms_idx = {fsel_ms4, fsel_ms3, fsel_ms2, fsel_ms1};
  wire       aux_ok = !pid_en;
  wire [W-1:0] stage1 = (fsrc == SRC_TERM) ? analog_input_one : preset_q[0];
  wire [W-1:0] stage2 = aux_mode ? preset_q[1] : analog_input_two;
  // pid disable moves stage one to the auxiliary input, never while pid is on
  wire [W-1:0] stage1_pid = (aux_ok && pid_off) ? analog_input_two : stage1;
  wire [W-1:0] ms_ref = (ms_idx == 4'h0) ? stage1_pid :
                        (ms_idx == 4'h1) ? stage2 : preset_q[ms_idx];
  wire [W-1:0] sel_ref = jog_sel ? jog_q : ms_ref;

  // up/down stepping
  wire updn_mode = (fsrc == SRC_UPDN);
  wire updn_err  = (up_asg ^ dn_asg) || (hold_in && (up_in || dn_in));
  wire up_only   = updn_mode && up_in && !dn_in && !hold_in;
  wire dn_only   = updn_mode && dn_in && !up_in && !hold_in;

  always_comb begin
    updn_d = updn_q;
    if (!run_req && !retain)
      updn_d = lower_q;
    else if (up_only && freq_output >= updn_q)
      updn_d = freq_output + W'(1);
    else if (dn_only && freq_output <= updn_q && freq_output != '0)
      updn_d = freq_output - W'(1);
    else if (updn_mode && !up_only && !dn_only && run_req && updn_q != freq_output
             && freq_output >= lower_q)
      updn_d = freq_output;
    updn_d = clamp(updn_d, lower_q, upper_q);
  end

  // reference arbitration: jog, then hold, then selected source
  wire [W-1:0] src_ref = (fsrc == SRC_UPDN) ? updn_q :
                         (alt_frq && !loc_mode && fsrc == SRC_KEYPAD) ? alt_freq_ref : sel_ref;
  // without retention a run started under hold must not leave zero
  wire hold_zero = hold_in && !retain && (freq_output == '0);

  always_comb begin
    tgt_d = src_ref;
    if (jog_run)
      tgt_d = jog_q;
    else if (hold_zero)
      tgt_d = '0;
    else if (hold_in && retain)
      tgt_d = saved_q;
  end

  always_comb begin
    mode_d = mode_q;
    unique case (mode_q)
      DFRIS_IDLE: begin
        if (estop_in)
          mode_d = DFRIS_ESTP;
        else if (run_req)
          mode_d = DFRIS_RAMP;
      end
      DFRIS_RAMP: begin
        if (estop_in)
          mode_d = DFRIS_ESTP;
        else if (!run_req)
          mode_d = DFRIS_IDLE;
      end
      DFRIS_ESTP: begin
        if (freq_output == '0)
          mode_d = DFRIS_HALT;
      end
      DFRIS_HALT: begin
        if (!estop_in && !run_req)
          mode_d = DFRIS_IDLE;
      end
    endcase
  end

  wire jog_expired = jog_run && (jog_cnt_q >= 32'(JOG_CYC));

  dfris_ramp_s rcmd;
  assign rcmd.target   = tgt_q;
  assign rcmd.acc_time = acc2_in ? acc2_q : acc1_q;
  assign rcmd.dec_time = (mode_q == DFRIS_ESTP) ? edec_q : (acc2_in ? dec2_q : dec1_q);
  assign rcmd.hold     = hold_in && (mode_q == DFRIS_RAMP);
  assign rcmd.run      = (mode_q == DFRIS_RAMP);

  dfris_ramp #(.W(W)) u_ramp (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .clk_en    (clk_en),
    .cmd       (rcmd),
    .freq_out  (freq_output),
    .at_target ()
  );

  // AHB-Lite slave: zero wait states, always OKAY
  wire       ap_valid = hsel && hready && htrans[1];
  wire [7:0] a_off    = ap_q.addr[7:0];
  wire       wr_en    = ap_q.sel && ap_q.write && clk_en;
  wire       is_pre   = pre_hit(a_off);
  wire [3:0] pre_idx  = pre_slot(a_off);
  wire [31:0] status_w = {26'h0, mode_q, jog_stop_q, input_config_error,
                          run_direction_warning, run_active};
  wire [31:0] rd_mux =
    (haddr[7:0] == A_CTRL)    ? ctrl_q :
    (haddr[7:0] == A_FUNC)    ? {22'h0, func_q[9:0]} | 32'(func_q[41:10]) << 10 :
    (haddr[7:0] == A_JOGF)    ? 32'(jog_q) :
    (haddr[7:0] == A_LIMITS)  ? {upper_q, lower_q} :
    (haddr[7:0] == A_TIMES1)  ? {dec1_q, acc1_q} :
    (haddr[7:0] == A_TIMES2)  ? {dec2_q, acc2_q} :
    (haddr[7:0] == A_ESTOP)   ? 32'(edec_q) :
    (haddr[7:0] == A_STATUS)  ? status_w :
    (haddr[7:0] == A_FREQOUT) ? {tgt_q, freq_output} :
    pre_hit(haddr[7:0])       ? 32'(preset_q[pre_slot(haddr[7:0])]) : 32'h0000_0000;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_q;

  // read data is fetched in the address phase so it stands through the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_q    <= '0;
      rdata_q <= 32'h0000_0000;
    end else if (clk_en) begin
      ap_q    <= '{sel: ap_valid, addr: haddr, write: hwrite};
      rdata_q <= (ap_valid && !hwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q  <= CTRL_RST;
      func_q  <= '0;
      jog_q   <= '0;
      upper_q <= UPPER_RST;
      lower_q <= '0;
      acc1_q  <= TIME_RST;
      dec1_q  <= TIME_RST;
      acc2_q  <= TIME_RST;
      dec2_q  <= TIME_RST;
      edec_q  <= TIME_RST;
      for (int i = 0; i < NUM_PRESET; i++) preset_q[i] <= '0;
    end else if (wr_en) begin
      if (a_off == A_CTRL)   ctrl_q  <= hwdata;
      if (a_off == A_FUNC)   func_q  <= hwdata[31:0] == 32'h0 ? '0 : {10'h0, hwdata};
      if (a_off == A_JOGF)   jog_q   <= hwdata[W-1:0];
      if (a_off == A_LIMITS) {upper_q, lower_q} <= hwdata;
      if (a_off == A_TIMES1) {dec1_q, acc1_q}   <= hwdata;
      if (a_off == A_TIMES2) {dec2_q, acc2_q}   <= hwdata;
      if (a_off == A_ESTOP)  edec_q  <= hwdata[W-1:0];
      if (is_pre)            preset_q[pre_idx] <= hwdata[W-1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_q     <= DFRIS_IDLE;
      updn_q     <= '0;
      saved_q    <= '0;
      tgt_q      <= '0;
      jog_cnt_q  <= '0;
      jog_stop_q <= 1'b0;
    end else if (clk_en) begin
      mode_q     <= mode_d;
      updn_q     <= updn_d;
      tgt_q      <= tgt_d;
      // reference kept across power loss only when retention is on
      if (retain && (power_loss || (hold_in && !hold_zero))) saved_q <= tgt_q;
      else if (!retain) saved_q <= '0;
      // the stop stays latched while the contact is held, so a wrapped count cannot restart it
      jog_cnt_q  <= jog_run ? jog_cnt_q + 32'h1 : '0;
      jog_stop_q <= jog_run && (jog_stop_q || jog_expired);
    end
  end

  assign freq_target           = tgt_q;
  assign run_active            = (mode_q == DFRIS_RAMP);
  assign run_reverse           = want_rev;
  assign jog_timeout_stop      = jog_stop_q;
  assign stop_coast            = jog_stop_q && stop_mode;
  assign run_direction_warning = dir_bad;
  assign input_config_error    = updn_err;

endmodule // dfris_top

// >>> testbench/dfris_properties.sv
/*
  concurrent checks on the frequency reference selector's ports.
  assumes it is bound to dfris_top with the same W parameter.
*/
`timescale 1ns/100ps
module dfris_properties
  import dfris_pkg::*;
#(
  parameter int unsigned W = FREQ_W
) (
  input wire logic              hclk,
  input wire logic              hresetn,
  input wire logic              clk_en,
  input wire logic              hsel,
  input wire logic [1:0]        htrans,
  input wire logic              hwrite,
  input wire logic              hready,
  input wire logic [31:0]       hrdata,
  input wire logic              hreadyout,
  input wire logic              hresp,
  input wire logic [NUM_DI-1:0] di_in,
  input wire logic              alt_run_fwd,
  input wire logic              alt_run_rev,
  input wire logic              local_run_fwd,
  input wire logic              local_run_rev,
  input wire logic [W-1:0]      freq_target,
  input wire logic [W-1:0]      freq_output,
  input wire logic              jog_timeout_stop,
  input wire logic              stop_coast,
  input wire logic              run_direction_warning
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  wire rd_req = hsel && hready && htrans[1] && !hwrite;
  wire any_cmd = (|di_in) || alt_run_fwd || alt_run_rev || local_run_fwd || local_run_rev;

  chk_ready_high: assert property (hreadyout) else $error("slave inserted a wait");
  chk_resp_okay: assert property (!hresp) else $error("slave answered with an error");
  chk_rdata_idle: assert property (!$past(rd_req) |-> hrdata == 32'h0000_0000)
    else $error("read data outside a read data phase");
  chk_coast_cause: assert property (stop_coast |-> jog_timeout_stop)
    else $error("coast stop without jog time-out");
  chk_dirwarn_cause: assert property (run_direction_warning |-> any_cmd)
    else $error("direction warning with no run command");
  chk_ramp_step: assert property ($changed(freq_output) |->
    (freq_output - $past(freq_output) == 1 || $past(freq_output) - freq_output == 1))
    else $error("output frequency jumped instead of ramping");
  chk_enable_freeze: assert property (!clk_en |=> $stable(freq_output) && $stable(freq_target))
    else $error("state moved while clock enable was low");
  chk_reset_zero: assert property ($rose(hresetn) |-> freq_output == 0 && freq_target == 0)
    else $error("frequency not zero after reset");

  cover property (rd_req);
  cover property ($rose(jog_timeout_stop));
  cover property ($rose(run_direction_warning));
endmodule // dfris_properties

// >>> testbench/dfris_contacts.sv
/*
  model of the external contacts and analog sources facing the selector.
  assumes the bench sets the contact pattern right after a rising edge.
*/
`timescale 1ns/100ps
module dfris_contacts
  import dfris_pkg::*;
#(
  parameter logic [FREQ_W-1:0] AIN1 = 16'h0321,
  parameter logic [FREQ_W-1:0] AIN2 = 16'h0432
) (
  input  wire logic                   hclk,
  input  wire logic [9:0]             press,
  output logic [NUM_DI-1:0]           di_in,
  output logic                        alt_run_fwd,
  output logic                        alt_run_rev,
  output logic                        local_run_fwd,
  output logic                        local_run_rev,
  output logic [FREQ_W-1:0]           analog_input_one,
  output logic [FREQ_W-1:0]           analog_input_two,
  output logic [FREQ_W-1:0]           alt_freq_ref
);
  // multi-function contacts close on a clock edge, like a synchronised terminal block; run contacts follow press at once;
  // jog and up/down contacts are only pressed with run source 1 selected
  initial di_in = '0;
  always @(posedge hclk) begin
    di_in <= press[NUM_DI-1:0];
  end
  assign alt_run_fwd      = press[6];
  assign alt_run_rev      = press[7];
  assign local_run_fwd    = press[8];
  assign local_run_rev    = press[9];
  assign analog_input_one = AIN1;
  assign analog_input_two = AIN2;
  assign alt_freq_ref     = 16'h0555;
endmodule // dfris_contacts

// >>> testbench/tb_top.sv
/*
  self-checking bench: register access over AHB-Lite, contact patterns
  from the contact model, checks on the selector's outputs.
  assumes zero-wait slave and a short jog time-out parameter.
*/
`timescale 1ns/100ps
module tb_top;
  import dfris_pkg::*;
  localparam int unsigned JOGC = 50;
  logic hclk, hresetn, clk_en, hsel, hwrite, power_loss;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic hready, hreadyout, hresp;
  logic [9:0] press;
  logic [NUM_DI-1:0] di_in;
  logic afwd, arev, lfwd, lrev, run_active, run_reverse, jstop, coast, dirwarn, cfgerr;
  logic [FREQ_W-1:0] ain1, ain2, aref, ftgt, fout;
  int fail_count, checks_done;

  assign hready = hreadyout;
  dfris_contacts dfris_contacts_i (.hclk(hclk), .press(press), .di_in(di_in),
    .alt_run_fwd(afwd), .alt_run_rev(arev), .local_run_fwd(lfwd), .local_run_rev(lrev),
    .analog_input_one(ain1), .analog_input_two(ain2), .alt_freq_ref(aref));
  dfris_top #(.JOG_CYC(JOGC)) dfris_top_i (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hready(hready), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .di_in(di_in), .analog_input_one(ain1), .analog_input_two(ain2), .alt_freq_ref(aref),
    .alt_run_fwd(afwd), .alt_run_rev(arev), .local_run_fwd(lfwd), .local_run_rev(lrev),
    .power_loss(power_loss), .freq_target(ftgt), .freq_output(fout),
    .run_active(run_active), .run_reverse(run_reverse), .jog_timeout_stop(jstop),
    .stop_coast(coast), .run_direction_warning(dirwarn), .input_config_error(cfgerr));

  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // bounded wait for hready; the slave never stalls, so a miss is a hang
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 20);
    if (n >= 20) begin
      fail_count++;
      $display("BAD at %0t: bus wait ran out", $time);
      finish_test();
    end
  endtask

  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd);
    hsel   <= 1'b1;
    haddr  <= {24'h00_0000, a};
    htrans <= 2'h2;
    hwrite <= w;
    hsize  <= 3'h2;
    wait_ready();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask

  task automatic contacts(input logic [9:0] p);
    press <= p;
    cyc(8);
  endtask

  // four 7-bit function codes for inputs 0..3; inputs 4..5 stay code 0
  function automatic logic [31:0] fn4(input logic [6:0] a, b, c, d);
    return {4'h0, d, c, b, a};
  endfunction

  initial begin
    {clk_en, hsel, hwrite, power_loss} = 4'b1000;
    {haddr, hwdata} = '0;
    htrans = 2'h0;
    hsize = 3'h2;
    press = '0;
    fail_count = 0;
    checks_done = 0;
    hresetn = 1'b0;
    cyc(3);
    hresetn <= 1'b1;
    bus(A_CTRL, 1'b0, 32'h0);
    check(rd, CTRL_RST);
    bus(A_TIMES1, 1'b0, 32'h0);
    check(rd, {TIME_RST, TIME_RST});
    bus(8'h3c, 1'b1, 32'h1234_5678);
    bus(8'h3c, 1'b0, 32'h0);
    check(rd, 32'h0);
    $display("register reset test done");
    for (int i = 0; i < 16; i++) bus(A_PRESET + 8'(4 * i), 1'b1, 32'(16'h0100 + 16 * i));
    bus(A_JOGF, 1'b1, 32'h0000_0777);
    bus(A_FUNC, 1'b1, fn4(FN_MS1, FN_MS2, FN_MS3, FN_MS4));
    bus(A_CTRL, 1'b1, 32'h0000_0800);
    for (int i = 0; i < 16; i++) begin
      contacts(10'(i));
      check(ftgt, 32'(16'h0100 + 16 * i));
    end
    clk_en <= 1'b0;
    contacts(10'h000);
    check(ftgt, 32'h0000_01f0);
    clk_en <= 1'b1;
    cyc(8);
    check(ftgt, 32'h0000_0100);
    bus(A_CTRL, 1'b1, 32'h0000_0001);
    cyc(8);
    check(ftgt, 32'(ain1));
    contacts(10'h001);
    check(ftgt, 32'(ain2));
    bus(A_FUNC, 1'b1, fn4(FN_MS1, FN_MS2, FN_MS3, FN_JOGSEL));
    contacts(10'h00f);
    check(ftgt, 32'h0000_0777);
    bus(A_FUNC, 1'b1, fn4(FN_PIDOFF, FN_MS1, FN_MS2, FN_MS3));
    contacts(10'h001);
    check(ftgt, 32'(ain2));
    bus(A_CTRL, 1'b1, 32'h0000_1001);
    cyc(8);
    check(ftgt, 32'(ain1));
    $display("preset select test done");
    bus(A_FUNC, 1'b1, fn4(FN_JOGF, FN_MS1, FN_MS2, FN_MS3));
    bus(A_CTRL, 1'b1, 32'h0000_2010);
    contacts(10'h007);
    check(ftgt, 32'h0000_0777);
    check(run_active, 1'b1);
    check(jstop, 1'b0);
    for (int n = 0; n < 200 && jstop !== 1'b1; n++) @(posedge hclk);
    check(jstop, 1'b1);
    check(coast, 1'b1);
    contacts(10'h000);
    $display("jog test done");
    bus(A_FUNC, 1'b1, fn4(FN_FWD, FN_REV, FN_MS1, FN_MS2));
    bus(A_CTRL, 1'b1, 32'h0000_0110);
    contacts(10'h002);
    check(dirwarn, 1'b1);
    check(run_reverse, 1'b1);
    contacts(10'h001);
    check(dirwarn, 1'b0);
    bus(A_CTRL, 1'b1, 32'h0000_0210);
    cyc(8);
    check(dirwarn, 1'b1);
    contacts(10'h000);
    $display("direction lock test done");
    bus(A_CTRL, 1'b1, 32'h0000_0012);
    bus(A_FUNC, 1'b1, fn4(FN_UP, FN_MS1, FN_HOLD, FN_MS2));
    cyc(8);
    check(cfgerr, 1'b1);
    bus(A_FUNC, 1'b1, fn4(FN_UP, FN_DOWN, FN_HOLD, FN_MS2));
    cyc(8);
    check(cfgerr, 1'b0);
    contacts(10'h005);
    check(cfgerr, 1'b1);
    contacts(10'h000);
    $display("up down config test done");
    bus(A_TIMES1, 1'b1, 32'h0002_0002);
    bus(A_LIMITS, 1'b1, 32'h0020_0010);
    contacts(10'h010);
    cyc(60);
    check(fout, 32'h0000_0010);
    contacts(10'h011);
    cyc(120);
    check(fout, 32'h0000_0020);
    contacts(10'h012);
    cyc(120);
    check(fout, 32'h0000_0010);
    bus(A_ESTOP, 1'b1, 32'h0000_0001);
    bus(A_FUNC, 1'b1, fn4(FN_UP, FN_DOWN, FN_ESTOP, FN_MS2));
    contacts(10'h014);
    cyc(30);
    check(fout, 32'h0000_0000);
    check(run_active, 1'b0);
    contacts(10'h000);
    $display("up down and stop test done");
    finish_test();
  end
endmodule // tb_top

bind dfris_top dfris_properties #(.W(W)) dfris_properties_i (.hclk(hclk), .hresetn(hresetn),
  .clk_en(clk_en), .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .di_in(di_in),
  .alt_run_fwd(alt_run_fwd), .alt_run_rev(alt_run_rev), .local_run_fwd(local_run_fwd),
  .local_run_rev(local_run_rev), .freq_target(freq_target), .freq_output(freq_output),
  .jog_timeout_stop(jog_timeout_stop), .stop_coast(stop_coast),
  .run_direction_warning(run_direction_warning));
